// file: rtl/tx_buffer_command_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "txcmd_map.svh"

module tx_buffer_command_decoder (
  input wire logic mclk_i,
  input wire logic resetn_i,
  txcmd_if.device link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire txcmd_pkg::dword_type wb_dat_i,
  output txcmd_pkg::dword_type wb_dat_o,
  output logic wb_ack_o,
  output logic [7:0] data_byte_o,
  output logic data_byte_valid_o,
  output logic packet_done_o,
  output logic irq_o
);
  import txcmd_pkg::*;

  typedef struct packed {
    dev_phase_type st;
    dword_type cmda;
    dword_type cmdb_ref;
    logic [15:0] sum;
    logic pkt_open;
    logic [9:0] left;
    logic [11:0] pos;
    dword_type word;
    logic [1:0] k;
    logic drop;
    logic [7:0] byte_d;
    logic byte_v;
    logic pkt_done;
    logic ready;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic ack;
    dword_type rdat;
  } dev_state_type;

  dev_state_type cur_ff;
  dev_state_type nxt_cur;

  logic take;
  logic fin;
  logic set_ld;
  logic set_err;
  logic wb_hit;
  logic [4:0] off;
  logic [10:0] size;
  logic [1:0] code;
  logic [11:0] e;
  logic [11:0] p;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.byte_v = 1'b0;
    nxt_cur.pkt_done = 1'b0;
    nxt_cur.ack = 1'b0;
    nxt_cur.rdat = '0;
    fin = 1'b0;
    set_ld = 1'b0;
    set_err = 1'b0;
    off = cur_ff.cmda[`CMDA_OFF_MSB:`CMDA_OFF_LSB];
    size = cur_ff.cmda[`CMDA_SIZE_MSB:0];
    code = cur_ff.cmda[`CMDA_ALIGN_MSB:`CMDA_ALIGN_LSB];
    e = {7'h00, off} + {1'h0, size};
    p = cur_ff.pos + {10'h000, cur_ff.k};
    take = link.valid & cur_ff.ready;
    case (cur_ff.st)
      dev_cmda: begin
        if (take) begin
          nxt_cur.cmda = link.word;
          nxt_cur.st = dev_cmdb;
        end
      end
      dev_cmdb: begin
        if (take) begin
          if (cur_ff.cmda[`CMDA_FIRST_BIT]) begin
            nxt_cur.sum = {5'h00, size};
            nxt_cur.cmdb_ref = link.word;
            nxt_cur.pkt_open = 1'b1;
          end else begin
            nxt_cur.sum = cur_ff.sum + {5'h00, size};
            // continuation without an opening segment cannot be summed
            if (!cur_ff.pkt_open || link.word != cur_ff.cmdb_ref) begin
              set_err = 1'b1;
            end
          end
          // reserved code: data still consumed so the stream stays in step
          nxt_cur.drop = (code == `ALIGN_RSVD);
          if (code == `ALIGN_RSVD) begin
            set_err = 1'b1;
          end
          nxt_cur.left = total_words(off, size, nxt_cur.drop ? `ALIGN_4 : code);
          nxt_cur.pos = '0;
          if (nxt_cur.left == 10'h000) begin
            fin = 1'b1;
          end else begin
            nxt_cur.st = dev_data;
          end
        end
      end
      dev_data: begin
        if (take) begin
          nxt_cur.word = link.word;
          if (!cur_ff.drop && cur_ff.pos < e && cur_ff.pos + 12'h004 > {7'h00, off}) begin
            nxt_cur.st = dev_emit;
            nxt_cur.k = 2'h0;
          end else begin
            // whole offset, filler or dropped dword, gone in one cycle
            nxt_cur.pos = cur_ff.pos + 12'h004;
            nxt_cur.left = cur_ff.left - 10'h001;
            if (cur_ff.left == 10'h001) begin
              fin = 1'b1;
            end
          end
        end
      end
      dev_emit: begin
        if (p >= {7'h00, off} && p < e) begin
          nxt_cur.byte_d = 8'(cur_ff.word >> {cur_ff.k, 3'h0});
          nxt_cur.byte_v = 1'b1;
        end
        nxt_cur.k = cur_ff.k + 2'h1;
        if (cur_ff.k == 2'h3) begin
          nxt_cur.pos = cur_ff.pos + 12'h004;
          nxt_cur.left = cur_ff.left - 10'h001;
          if (cur_ff.left == 10'h001) begin
            fin = 1'b1;
          end else begin
            nxt_cur.st = dev_data;
          end
        end
      end
      default: begin
        nxt_cur.st = dev_cmda;
      end
    endcase
    if (fin) begin
      nxt_cur.st = dev_cmda;
      if (cur_ff.cmda[`CMDA_IRQ_BIT]) begin
        set_ld = 1'b1;
      end
      if (cur_ff.cmda[`CMDA_LAST_BIT]) begin
        nxt_cur.pkt_open = 1'b0;
        nxt_cur.pkt_done = 1'b1;
        if (nxt_cur.sum != {5'h00, nxt_cur.cmdb_ref[`CMDB_LEN_MSB:0]}) begin
          set_err = 1'b1;
        end
      end
    end
    wb_hit = wb_cyc_i & wb_stb_i & ~cur_ff.ack;
    if (wb_hit) begin
      nxt_cur.ack = 1'b1;
      if (wb_we_i) begin
        if (wb_adr_i == `DEV_STATUS_ADR && wb_sel_i[0]) begin
          nxt_cur.status = cur_ff.status & ~wb_dat_i[1:0];
        end else if (wb_adr_i == `DEV_MASK_ADR && wb_sel_i[0]) begin
          nxt_cur.mask = wb_dat_i[1:0];
        end
      end else begin
        if (wb_adr_i == `DEV_STATUS_ADR) begin
          nxt_cur.rdat = {30'h00000000, cur_ff.status};
        end else if (wb_adr_i == `DEV_MASK_ADR) begin
          nxt_cur.rdat = {30'h00000000, cur_ff.mask};
        end
      end
    end
    // set after clear, so a same-cycle event survives
    nxt_cur.status[`ST_LD_BIT] = nxt_cur.status[`ST_LD_BIT] | set_ld;
    nxt_cur.status[`ST_ERR_BIT] = nxt_cur.status[`ST_ERR_BIT] | set_err;
    nxt_cur.irq = |(nxt_cur.status & nxt_cur.mask);
    nxt_cur.ready = (nxt_cur.st != dev_emit);
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_ff <= '0;
      cur_ff.status <= `STATUS_RESET;
      cur_ff.mask <= `MASK_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign link.ready = cur_ff.ready;
  assign wb_dat_o = cur_ff.rdat;
  assign wb_ack_o = cur_ff.ack;
  assign data_byte_o = cur_ff.byte_d;
  assign data_byte_valid_o = cur_ff.byte_v;
  assign packet_done_o = cur_ff.pkt_done;
  assign irq_o = cur_ff.irq;

endmodule

`default_nettype wire

// file: rtl/txcmd_map.svh
`ifndef TXCMD_MAP_SVH
`define TXCMD_MAP_SVH

`define CMDA_IRQ_BIT 31
`define CMDA_ALIGN_MSB 25
`define CMDA_ALIGN_LSB 24
`define CMDA_OFF_MSB 20
`define CMDA_OFF_LSB 16
`define CMDA_FIRST_BIT 13
`define CMDA_LAST_BIT 12
`define CMDA_SIZE_MSB 10
`define CMDA_RSVD_MASK 32'h00E0C800
`define CMDB_LEN_MSB 10

`define ALIGN_4 2'h0
`define ALIGN_16 2'h1
`define ALIGN_32 2'h2
`define ALIGN_RSVD 2'h3

`define DEV_STATUS_ADR 8'h00
`define DEV_MASK_ADR 8'h04
`define HOST_DATA_ADR 8'h00
`define HOST_STATUS_ADR 8'h04

`define ST_LD_BIT 0
`define ST_ERR_BIT 1
`define STATUS_RESET 2'h0
`define MASK_RESET 2'h0

`endif

// file: rtl/txcmd_pkg.sv
`default_nettype none
`include "txcmd_map.svh"

package txcmd_pkg;

  typedef logic [31:0] dword_type;

  typedef enum logic [1:0] {
    dev_cmda,
    dev_cmdb,
    dev_data,
    dev_emit
  } dev_phase_type;

  typedef enum logic [1:0] {
    host_cmda,
    host_cmdb,
    host_data,
    host_fill
  } host_phase_type;

  // dwords from start of data region to the aligned end
  function automatic logic [9:0] total_words(input logic [4:0] off, input logic [10:0] size,
                                             input logic [1:0] code);
    logic [11:0] e;
    logic [11:0] r;
    e = {7'h00, off} + {1'h0, size};
    case (code)
      `ALIGN_16: r = (e + 12'h00F) & 12'hFF0;
      `ALIGN_32: r = (e + 12'h01F) & 12'hFE0;
      default: r = (e + 12'h003) & 12'hFFC;
    endcase
    return r[11:2];
  endfunction

  function automatic dword_type sel_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

endpackage

`default_nettype wire

// file: rtl/txcmd_if.sv
`timescale 1ns/100ps
`default_nettype none

interface txcmd_if;
  import txcmd_pkg::*;
  dword_type word;
  logic valid;
  logic ready;

  modport host (output word, output valid, input ready);
  modport device (input word, input valid, output ready);
endinterface

`default_nettype wire

// file: rtl/tx_buffer_writer.sv
`timescale 1ns/100ps
`default_nettype none
`include "txcmd_map.svh"

module tx_buffer_writer (
  input wire logic mclk_i,
  input wire logic resetn_i,
  txcmd_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire txcmd_pkg::dword_type wb_dat_i,
  output txcmd_pkg::dword_type wb_dat_o,
  output logic wb_ack_o
);
  import txcmd_pkg::*;

  typedef struct packed {
    host_phase_type st;
    dword_type word;
    logic valid;
    logic [9:0] data_left;
    logic [9:0] fill_left;
    logic ack;
    dword_type rdat;
  } host_state_type;

  host_state_type cur_ff;
  host_state_type nxt_cur;

  logic wb_hit;
  logic can_load;
  dword_type w;
  logic [1:0] code;
  logic [9:0] tot;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.ack = 1'b0;
    nxt_cur.rdat = '0;
    w = wb_dat_i & sel_mask(wb_sel_i);
    if (cur_ff.st == host_cmda) begin
      w = w & ~`CMDA_RSVD_MASK;
    end
    code = w[`CMDA_ALIGN_MSB:`CMDA_ALIGN_LSB];
    tot = total_words(w[`CMDA_OFF_MSB:`CMDA_OFF_LSB], w[`CMDA_SIZE_MSB:0],
                      code == `ALIGN_RSVD ? `ALIGN_4 : code);
    if (cur_ff.valid && link.ready) begin
      nxt_cur.valid = 1'b0;
      case (cur_ff.st)
        host_cmda: begin
          nxt_cur.st = host_cmdb;
        end
        host_cmdb: begin
          if (cur_ff.data_left != 10'h000) begin
            nxt_cur.st = host_data;
          end else if (cur_ff.fill_left != 10'h000) begin
            nxt_cur.st = host_fill;
          end else begin
            nxt_cur.st = host_cmda;
          end
        end
        host_data: begin
          nxt_cur.data_left = cur_ff.data_left - 10'h001;
          if (cur_ff.data_left == 10'h001) begin
            nxt_cur.st = (cur_ff.fill_left != 10'h000) ? host_fill : host_cmda;
          end
        end
        default: begin
          nxt_cur.fill_left = cur_ff.fill_left - 10'h001;
          if (cur_ff.fill_left == 10'h001) begin
            nxt_cur.st = host_cmda;
          end
        end
      endcase
    end
    // filler made here so software never has to count it
    if (nxt_cur.st == host_fill && !nxt_cur.valid) begin
      nxt_cur.valid = 1'b1;
      nxt_cur.word = '0;
    end
    can_load = ~cur_ff.valid & (cur_ff.st != host_fill);
    wb_hit = wb_cyc_i & wb_stb_i & ~cur_ff.ack;
    if (wb_hit) begin
      if (wb_we_i && wb_adr_i == `HOST_DATA_ADR) begin
        // ack held back while the link word is pending
        if (can_load) begin
          nxt_cur.ack = 1'b1;
          nxt_cur.word = w;
          nxt_cur.valid = 1'b1;
          if (cur_ff.st == host_cmda) begin
            nxt_cur.data_left = total_words(w[`CMDA_OFF_MSB:`CMDA_OFF_LSB],
                                            w[`CMDA_SIZE_MSB:0], `ALIGN_4);
            nxt_cur.fill_left = tot - nxt_cur.data_left;
          end
        end
      end else begin
        nxt_cur.ack = 1'b1;
        if (!wb_we_i && wb_adr_i == `HOST_STATUS_ADR) begin
          nxt_cur.rdat = {28'h0000000, cur_ff.st, 1'b0, ~can_load};
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign link.word = cur_ff.word;
  assign link.valid = cur_ff.valid;
  assign wb_dat_o = cur_ff.rdat;
  assign wb_ack_o = cur_ff.ack;

endmodule

`default_nettype wire

// file: bench/txcmd_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "txcmd_map.svh"

module txcmd_assertions (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire txcmd_pkg::dword_type word,
  input wire logic valid,
  input wire logic ready
);
  import txcmd_pkg::*;
  logic [1:0] ph_ff, code_ff;
  logic [4:0] off_ff;
  logic [10:0] size_ff;
  logic [9:0] tot_ff, idx_ff;
  logic [11:0] lo, hi;
  logic take, pay, fill;
  // own rounding, so a slip shared with the design cannot hide
  function automatic logic [9:0] nwords(input logic [11:0] e, input logic [1:0] c);
    logic [11:0] m;
    m = (c == 2'h1) ? 12'h00F : (c == 2'h2) ? 12'h01F : 12'h003;
    return 10'(((e + m) & ~m) >> 2);
  endfunction
  assign take = valid && ready;
  assign lo = {idx_ff, 2'h0};
  assign hi = {7'h00, off_ff} + {1'h0, size_ff};
  assign pay = (lo + 12'h003 >= {7'h00, off_ff}) && (lo < hi);
  assign fill = lo >= ((hi + 12'h003) & 12'hFFC);
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ph_ff <= 2'h0;
      code_ff <= 2'h0;
      off_ff <= 5'h00;
      size_ff <= 11'h000;
      tot_ff <= 10'h000;
      idx_ff <= 10'h000;
    end else if (take) begin
      case (ph_ff)
        2'h0: begin
          off_ff <= word[20:16];
          size_ff <= word[10:0];
          code_ff <= word[25:24];
          tot_ff <= nwords({7'h00, word[20:16]} + {1'h0, word[10:0]}, word[25:24]);
          ph_ff <= 2'h1;
        end
        2'h1: begin
          idx_ff <= 10'h000;
          ph_ff <= (tot_ff == 10'h000) ? 2'h0 : 2'h2;
        end
        default: begin
          idx_ff <= idx_ff + 10'h001;
          ph_ff <= (idx_ff + 10'h001 == tot_ff) ? 2'h0 : 2'h2;
        end
      endcase
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  property p_rsvd; take && ph_ff == 2'h0 |-> (word & `CMDA_RSVD_MASK) == 32'h00000000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_hold; valid && !ready |=> valid; endproperty
  a_hold: assert property (p_hold) else $error("valid dropped");
  property p_stab; valid && !ready |=> $stable(word); endproperty
  a_stab: assert property (p_stab) else $error("word moved");
  property p_four; $fell(ready) |-> !ready [*4] ##1 ready; endproperty
  a_four: assert property (p_four) else $error("emit length");
  property p_cause; $fell(ready) |-> $past(take) && $past(ph_ff) == 2'h2; endproperty
  a_cause: assert property (p_cause) else $error("stall without data");
  property p_pay; take && ph_ff == 2'h2 && pay && code_ff != 2'h3 |=> !ready; endproperty
  a_pay: assert property (p_pay) else $error("payload not emitted");
  property p_skip; take && !(ph_ff == 2'h2 && pay) |=> ready; endproperty
  a_skip: assert property (p_skip) else $error("filler emitted");
  property p_fill; take && ph_ff == 2'h2 && fill |-> word == 32'h00000000; endproperty
  a_fill: assert property (p_fill) else $error("filler not zero");
endmodule

`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  import txcmd_pkg::*;
  logic mclk_i, resetn_i;
  logic [1:0] cyc, stb, we;
  logic [3:0] sel;
  logic [7:0] adr [2];
  dword_type wdat [2];
  dword_type q;
  wire [1:0] ack;
  wire [31:0] rdat [2];
  wire [7:0] dbyte;
  wire dvalid, pdone, irq;
  logic [7:0] got[$], exp[$];
  int failures, checked, dones;
  txcmd_if link ();
  tx_buffer_command_decoder u_tx_buffer_command_decoder (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .link(link.device), .wb_cyc_i(cyc[0]), .wb_stb_i(stb[0]), .wb_we_i(we[0]), .wb_adr_i(adr[0]),
    .wb_sel_i(sel), .wb_dat_i(wdat[0]), .wb_dat_o(rdat[0]), .wb_ack_o(ack[0]),
    .data_byte_o(dbyte), .data_byte_valid_o(dvalid), .packet_done_o(pdone), .irq_o(irq));
  tx_buffer_writer u_tx_buffer_writer (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(link.host),
    .wb_cyc_i(cyc[1]), .wb_stb_i(stb[1]), .wb_we_i(we[1]), .wb_adr_i(adr[1]), .wb_sel_i(sel),
    .wb_dat_i(wdat[1]), .wb_dat_o(rdat[1]), .wb_ack_o(ack[1]));
  txcmd_assertions u_txcmd_assertions (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .word(link.word), .valid(link.valid), .ready(link.ready));
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    if (dvalid === 1'b1) got.push_back(dbyte);
    if (pdone === 1'b1) dones++;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask
  // s picks the bus: 0 decoder, 1 writer
  task automatic wb(input int s, input logic w, input logic [7:0] a, input dword_type d);
    @(posedge mclk_i);
    cyc[s] <= 1'b1;
    stb[s] <= 1'b1;
    we[s] <= w;
    adr[s] <= a;
    wdat[s] <= d;
    do @(posedge mclk_i); while (ack[s] !== 1'b1);
    q = rdat[s];
    cyc[s] <= 1'b0;
    stb[s] <= 1'b0;
  endtask
  // flg is {irq, first, last}; reserved ones are set on purpose
  task automatic send(input logic [1:0] c, input logic [4:0] off, input logic [10:0] n,
                      input logic [2:0] flg, input logic [15:0] tag, input logic [10:0] len);
    int d0;
    d0 = dones;
    wb(1, 1'b1, 8'h00, {flg[2], 5'h00, c, 3'h7, off, 2'h3, flg[1:0], 1'b1, n});
    wb(1, 1'b1, 8'h00, {tag, 5'h00, len});
    for (int i = 0; i < (off + n + 3) / 4; i++)
      wb(1, 1'b1, 8'h00, {8'(4 * i + 19), 8'(4 * i + 18), 8'(4 * i + 17), 8'(4 * i + 16)});
    for (int p = off; p < off + n; p++)
      if (c != 2'h3) exp.push_back(8'(p + 16));
    if (flg[0]) while (dones == d0) @(posedge mclk_i);
  endtask
  task automatic fin(input string name, input logic [1:0] st, input logic m);
    check(name, got.size(), exp.size());
    foreach (exp[i]) check(name, got[i], exp[i]);
    wb(0, 1'b0, 8'h00, 32'h00000000);
    check(name, q, {30'h0, st});
    check(name, irq, m);
    wb(0, 1'b1, 8'h00, 32'h00000003);
    @(negedge mclk_i);
    check(name, irq, 1'b0);
    got.delete();
    exp.delete();
    $display("test %s done", name);
  endtask
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    resetn_i = 1'b0;
    cyc = 2'h0;
    stb = 2'h0;
    we = 2'h0;
    sel = 4'hF;
    adr = '{8'h00, 8'h00};
    wdat = '{32'h00000000, 32'h00000000};
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    wb(0, 1'b0, 8'h00, 32'h00000000);
    check("reset status", q, 32'h00000000);
    wb(0, 1'b1, 8'h04, 32'h00000001);
    for (int c = 0; c < 3; c++) begin
      send(2'(c), 5'h05, 11'h009, 3'h7, 16'hA5A5, 11'h009);
      fin("align", 2'h1, 1'b1);
    end
    send(2'h0, 5'h1F, 11'h003, 3'h2, 16'h0001, 11'h009);
    send(2'h1, 5'h00, 11'h006, 3'h1, 16'h0001, 11'h009);
    fin("segments", 2'h0, 1'b0);
    send(2'h2, 5'h02, 11'h007, 3'h7, 16'h0002, 11'h008);
    fin("length", 2'h3, 1'b1);
    send(2'h3, 5'h00, 11'h008, 3'h3, 16'h0003, 11'h008);
    fin("reserved", 2'h2, 1'b0);
    wb(0, 1'b1, 8'h04, 32'h00000002);
    send(2'h0, 5'h00, 11'h004, 3'h2, 16'h0004, 11'h008);
    send(2'h0, 5'h00, 11'h004, 3'h1, 16'h0005, 11'h008);
    fin("cmdb", 2'h2, 1'b1);
    // closing segment with no packet open must flag an error
    send(2'h0, 5'h00, 11'h004, 3'h1, 16'h0006, 11'h004);
    fin("orphan", 2'h2, 1'b1);
    wb(0, 1'b0, 8'h04, 32'h00000000);
    check("mask", q, 32'h00000002);
    wb(0, 1'b0, 8'h08, 32'h00000000);
    check("unmapped", q, 32'h00000000);
    // one pulse per closing segment, none for opening-only buffers
    check("done count", dones, 8);
    wb(1, 1'b0, 8'h04, 32'h00000000);
    check("host idle", q, 32'h00000000);
    report_and_stop();
  end
  // the whole run takes a few hundred cycles; 20000 is far above it
  initial begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    report_and_stop();
  end
endmodule

`default_nettype wire
